// [src/shp_cfg.svh]
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH
`define SHP_CMD_WR 8'h61
`define SHP_CMD_RD 8'h41
`define SHP_REG_BASE 16'h0800
`define SHP_ADDR_STEP 16'h0004
`define SHP_LEN_ZERO 9'h100
`define SHP_LAST_BIT 5'h1f
`define SHP_SYS_CLK_NS 50
`define SHP_IO_FAULT_NS 200000
`define SHP_IO_FAULT_CYC (`SHP_IO_FAULT_NS / `SHP_SYS_CLK_NS)
`define SHP_SYNC_W 10
`define SHP_SYNC_RST 10'h004
`endif

// [src/shp_pkg.sv]
package shp_pkg;
   typedef enum logic [1:0] {
      SHP_STANDBY = 2'b00,
      SHP_NORMAL  = 2'b01,
      SHP_SLEEP   = 2'b10
   } shp_mode_type;
   // Supervisor inputs, all from outside the clock domain.
   typedef struct packed {
      logic supply_undervoltage;
      logic io_rail_undervoltage;
      logic regulator_low;
      logic thermal_shutdown;
      logic wake_event;
      logic xcvr_enable;
      logic normal_request;
   } shp_pins_type;
   // Protected-state drive for the transceiver and host pins.
   typedef struct packed {
      logic bus_float;
      logic bus_recessive;
      logic rx_force_high;
      logic rx_float;
      logic wake_rx_on;
      logic regulator_on;
      logic xcvr_standby;
      logic host_io_on;
   } shp_prot_type;
endpackage : shp_pkg

// [src/shp_top.sv]
`timescale 1ns/100ps
`include "shp_cfg.svh"
// What this block does
// (RL1) Transfers are 32-bit words; first word is command, address, length.
// (RL2) Serial output of every transfer starts with the global status byte.
// (RL3) Writes shift out the old register contents before replacing them.
// (RL4) Reads shift out present contents and leave registers unchanged.
// (RL5) Input sampled on rising clock, output changes on falling clock.
// (RL6) Serial output floats while select is high, driven only when low.
// (RL7) At select fall the output shows the global fault flag at once.
// (RL8) Write data commits only after a whole 32-bit word has arrived.
// (RL9) Bit count not a multiple of 32 drops last word, sets framing flag.
// (RL10) Host wires the device as a bus slave, never in a daisy chain.
// (RL11) Supply undervoltage sets flag, stops regulator, transceiver standby.
// (RL12) Power-on reset shuts all down and clears every register.
// (RL13) Rail undervoltage disables host I/O and times out into sleep.
// (RL14) Sleep needs a wake to reach standby; sleep clears registers.
// (RL15) Rail undervoltage during thermal shutdown enters sleep at once.
// (RL16) Protected states float or hold bus and receive output per fault.
// (RL17) Enable low with supply undervoltage kills wake receiver, floats rx.
// (RL18) Host waits the mode switch delay after faults clear.
// (RL19) Fault normal-to-standby sets core init; normal again clears, resumes.
// (RL20) Host zeroes the message RAM after power-up, reset and wake.
// (RL21) Host writes at least two payload words per transmit element.
// (RL22) The two lowest address bits are ignored on every access.
// (RL23) Burst write code 8'h61, burst read code 8'h41.
// (RL24) A length byte of zero means 256 data words.
// (RL25) The word address steps by one word per burst data word.
module shp_top
   import shp_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         spi_clk,
   input  wire logic         host_select_low,
   input  wire logic         serial_in_pin,
   output logic              serial_out_pin,
   output logic              serial_out_oe_n,
   input  wire shp_pins_type pins,
   input  wire logic         flag_clear,
   output shp_mode_type      mode,
   output logic              framing_error_flag,
   output logic              regulator_undervoltage,
   output logic              io_uv_flag,
   output logic              core_init_bit,
   output logic              tx_resume,
   output logic              inhibit_output,
   output shp_prot_type      prot
);
   localparam int IO_CYC = `SHP_IO_FAULT_CYC;

   // Supervisor, synchroniser and link state.
   logic [`SHP_SYNC_W-1:0] s1_q, s2_q, s3_q, ag_q, ag_d;
   shp_pins_type           pf, pf_prev_q;
   logic                   sel_s, sel_prev_q, sel_rise, st_tgl_s, dn_tgl_s;
   shp_mode_type           mode_q, mode_d;
   logic [12:0]            io_cnt_q, io_cnt_d;
   logic                   init_q, init_d, resume_q, resume_d;
   logic                   ruv_q, ruv_d, iouv_q, iouv_d, ferr_q, ferr_d;
   logic                   sleep_q, fault, io_expire;
   logic [7:0]             stat_q, stat_d;
   shp_prot_type           prot_q, prot_d;
   logic [7:0]             ls1_q, ls2_q, ls3_q, lstat_q, lstat_d;
   logic                   lrst_n, rf_rst_n;
   logic [4:0]             bit_q, bit_d;
   logic                   hdr_q, hdr_d;
   logic [7:0]             cmd_q, cmd_d;
   logic [15:0]            addr_q, addr_d;
   logic [8:0]             left_q, left_d;
   logic [30:0]            sin_q;
   logic [31:0]            word, rd_word, sout_q, sout_d;
   logic [31:0]            regs_q [8];
   logic [31:0]            regs_d [8];
   logic                   st_tgl_q, dn_tgl_q, started_q, hit, cmd_ok;
   logic [2:0]             idx;
   logic                   tgl_ref_q, tgl_ref_d, frame_odd;
   logic [12:0]            uv_age_q, uv_age_d;

   // Each outside bit passes three flops; a change counts once the
   // second and third stages agree.
   genvar gi;
   generate
      for (gi = 0; gi < `SHP_SYNC_W; gi++) begin : g_sync
         assign ag_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : ag_q[gi];
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= `SHP_SYNC_RST;
         s2_q <= `SHP_SYNC_RST;
         s3_q <= `SHP_SYNC_RST;
         ag_q <= `SHP_SYNC_RST;
      end else begin
         s1_q <= {pins, host_select_low, st_tgl_q, dn_tgl_q};
         s2_q <= s1_q;
         s3_q <= s2_q;
         ag_q <= ag_d;
      end
   end

   assign pf       = ag_q[9:3];
   assign sel_s    = ag_q[2];
   assign st_tgl_s = ag_q[1];
   assign dn_tgl_s = ag_q[0];
   assign sel_rise = sel_s & ~sel_prev_q;
   assign fault    = pf.io_rail_undervoltage | pf.regulator_low |
                     pf.supply_undervoltage | pf.thermal_shutdown;
   assign io_expire = io_cnt_q == 13'(IO_CYC - 1);
   assign frame_odd = st_tgl_s ^ dn_tgl_s ^ tgl_ref_q; // RL9

   // Mode, fault timer, sticky flags and protected-state drive.
   always_comb begin
      mode_d   = mode_q;
      init_d   = init_q;
      resume_d = 1'b0;
      io_cnt_d = 13'h0;
      if (pf.io_rail_undervoltage && mode_q != SHP_SLEEP && !io_expire)
         io_cnt_d = io_cnt_q + 13'h1; // RL13
      case (mode_q)
         SHP_NORMAL: begin
            if (fault) begin
               mode_d = SHP_STANDBY;
               init_d = 1'b1; // RL19
            end else if (!pf.normal_request) begin
               mode_d = SHP_STANDBY;
            end
         end
         SHP_STANDBY: begin
            if (pf.normal_request && !fault) begin
               mode_d   = SHP_NORMAL;
               init_d   = 1'b0; // RL19
               resume_d = 1'b1; // RL19
            end
         end
         SHP_SLEEP: begin
            if (pf.wake_event)
               mode_d = SHP_STANDBY; // RL14
         end
         default: mode_d = SHP_STANDBY;
      endcase
      if (mode_q != SHP_SLEEP && pf.io_rail_undervoltage &&
          (pf.thermal_shutdown || io_expire))
         mode_d = SHP_SLEEP; // RL13 RL15
      // Hardware sets win over a clear in the same cycle.
      ruv_d  = (pf.supply_undervoltage & ~pf_prev_q.supply_undervoltage) |
               (ruv_q & ~flag_clear); // RL11
      iouv_d = (pf.io_rail_undervoltage & ~pf_prev_q.io_rail_undervoltage) |
               (iouv_q & ~flag_clear);
      ferr_d = (sel_rise & frame_odd) | (ferr_q & ~flag_clear); // RL9
      // Parity kept from the last select rise; a partial word flips it.
      tgl_ref_d = sel_rise ? (st_tgl_s ^ dn_tgl_s) : tgl_ref_q; // RL9
      if (mode_q == SHP_SLEEP) begin
         ruv_d  = 1'b0; // RL14
         iouv_d = 1'b0;
         ferr_d = 1'b0;
      end
      stat_d = {ruv_q | iouv_q | ferr_q | pf.thermal_shutdown,
                ferr_q, ruv_q, iouv_q, pf.thermal_shutdown, init_q,
                mode_q}; // RL2
      prot_d.bus_float     = pf.supply_undervoltage | pf.regulator_low;
      prot_d.rx_float      = pf.io_rail_undervoltage |
                             (~pf.xcvr_enable & pf.supply_undervoltage);
      prot_d.rx_force_high = prot_d.bus_float & ~prot_d.rx_float; // RL16
      prot_d.bus_recessive = pf.io_rail_undervoltage &
                             ~prot_d.bus_float; // RL16
      prot_d.wake_rx_on    = ~(~pf.xcvr_enable &
                               pf.supply_undervoltage); // RL17
      prot_d.regulator_on  = ~(pf.supply_undervoltage |
                               pf.thermal_shutdown |
                               (mode_q == SHP_SLEEP)); // RL11
      prot_d.xcvr_standby  = (mode_q != SHP_NORMAL) | fault; // RL11
      prot_d.host_io_on    = ~pf.io_rail_undervoltage; // RL13
   end

   // Power-on reset clears every flag and state, but sets the select history high.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin // RL12
         mode_q     <= SHP_STANDBY;
         io_cnt_q   <= 13'h0;
         init_q     <= 1'b0;
         resume_q   <= 1'b0;
         ruv_q      <= 1'b0;
         iouv_q     <= 1'b0;
         ferr_q     <= 1'b0;
         sleep_q    <= 1'b0;
         stat_q     <= 8'h00;
         prot_q     <= '0;
         pf_prev_q  <= '0;
         sel_prev_q <= 1'b1;
         tgl_ref_q  <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         io_cnt_q   <= io_cnt_d;
         init_q     <= init_d;
         resume_q   <= resume_d;
         ruv_q      <= ruv_d;
         iouv_q     <= iouv_d;
         ferr_q     <= ferr_d;
         sleep_q    <= mode_d == SHP_SLEEP;
         stat_q     <= stat_d;
         prot_q     <= prot_d;
         pf_prev_q  <= pf;
         sel_prev_q <= sel_s;
         tgl_ref_q  <= tgl_ref_d;
      end
   end

   assign mode                   = mode_q;
   assign core_init_bit          = init_q;
   assign tx_resume              = resume_q;
   assign regulator_undervoltage = ruv_q;
   assign io_uv_flag             = iouv_q;
   assign framing_error_flag     = ferr_q;
   assign inhibit_output         = ~sleep_q; // RL14
   assign prot                   = prot_q;

   // Status byte into the link clock, three stages with agreement.
   assign lstat_d = (ls2_q == ls3_q) ? ls3_q : lstat_q;
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         ls1_q   <= 8'h00;
         ls2_q   <= 8'h00;
         ls3_q   <= 8'h00;
         lstat_q <= 8'h00;
      end else begin
         ls1_q   <= stat_q;
         ls2_q   <= ls1_q;
         ls3_q   <= ls2_q;
         lstat_q <= lstat_d;
      end
   end

   // Frame state is cleared by select going high; registers by sleep.
   assign lrst_n   = rst_n & ~host_select_low;
   assign rf_rst_n = rst_n & ~sleep_q; // RL14
   assign word     = {sin_q, serial_in_pin}; // RL5
   assign hit      = addr_q[15:5] == 11'(`SHP_REG_BASE >> 5); // RL22
   assign idx      = addr_q[4:2]; // RL22
   assign cmd_ok   = (cmd_q == `SHP_CMD_WR) || (cmd_q == `SHP_CMD_RD);

   // Header capture, burst stepping and word-complete writes.
   always_comb begin
      bit_d  = bit_q + 5'h1;
      hdr_d  = hdr_q;
      cmd_d  = cmd_q;
      addr_d = addr_q;
      left_d = left_q;
      for (int i = 0; i < 8; i++)
         regs_d[i] = regs_q[i];
      if (bit_q == `SHP_LAST_BIT) begin // RL8
         if (!hdr_q) begin // RL1
            hdr_d  = 1'b1;
            cmd_d  = word[31:24];
            addr_d = word[23:8];
            left_d = (word[7:0] == 8'h00) ? `SHP_LEN_ZERO
                                          : {1'b0, word[7:0]}; // RL24
         end else if (left_q != 9'h0) begin
            if (cmd_q == `SHP_CMD_WR && hit)
               regs_d[idx] = word; // RL8 RL23
            addr_d = addr_q + `SHP_ADDR_STEP; // RL25
            left_d = left_q - 9'h1;
         end
      end
   end

   always_ff @(posedge spi_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         bit_q  <= 5'h0;
         hdr_q  <= 1'b0;
         cmd_q  <= 8'h00;
         addr_q <= 16'h0000;
         left_q <= 9'h0;
         sin_q  <= 31'h0;
      end else begin
         bit_q  <= bit_d;
         hdr_q  <= hdr_d;
         cmd_q  <= cmd_d;
         addr_q <= addr_d;
         left_q <= left_d;
         sin_q  <= word[30:0]; // RL5
      end
   end

   // Register storage; a read command never reaches the write path.
   always_ff @(posedge spi_clk or negedge rf_rst_n) begin
      if (!rf_rst_n) begin
         for (int i = 0; i < 8; i++)
            regs_q[i] <= 32'h0;
      end else begin
         for (int i = 0; i < 8; i++)
            regs_q[i] <= regs_d[i]; // RL4
      end
   end

   // Word start and end toggles tell the supervisor about framing.
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_tgl_q <= 1'b0;
         dn_tgl_q <= 1'b0;
      end else begin
         st_tgl_q <= st_tgl_q ^ (bit_q == 5'h0);
         dn_tgl_q <= dn_tgl_q ^ (bit_q == `SHP_LAST_BIT); // RL9
      end
   end

   // Output word: old register contents, loaded before any write.
   assign rd_word = (hdr_q && left_q != 9'h0 && cmd_ok && hit) ?
                    regs_q[idx] : 32'h0; // RL3 RL4
   always_comb begin
      if (!started_q)
         sout_d = {lstat_q[6:0], 25'h0}; // RL2
      else if (bit_q == 5'h0)
         sout_d = rd_word;
      else
         sout_d = {sout_q[30:0], 1'b0};
   end

   always_ff @(negedge spi_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         sout_q    <= 32'h0;
         started_q <= 1'b0;
      end else begin
         sout_q    <= sout_d; // RL5
         started_q <= 1'b1;
      end
   end

   assign serial_out_pin  = started_q ? sout_q[31] : stat_q[7]; // RL7
   assign serial_out_oe_n = host_select_low | ~prot_q.host_io_on; // RL6

   property p_oe_off;
      @(posedge sys_clk) disable iff (!rst_n)
      host_select_low |-> serial_out_oe_n;
   endproperty
   a_oe_off: assert property (p_oe_off) // RL6
      else $error("output driven while deselected");

   property p_fault_first;
      @(posedge sys_clk) disable iff (!rst_n)
      !started_q |-> serial_out_pin == stat_q[7];
   endproperty
   a_fault_first: assert property (p_fault_first) // RL7
      else $error("first bit is not the fault flag");

   property p_frame_err;
      @(posedge sys_clk) disable iff (!rst_n)
      sel_rise && frame_odd && mode_q != SHP_SLEEP
      |=> framing_error_flag;
   endproperty
   a_frame_err: assert property (p_frame_err) // RL9
      else $error("partial word did not set framing flag");

   property p_init_set;
      @(posedge sys_clk) disable iff (!rst_n)
      mode_q == SHP_NORMAL && fault && !io_expire &&
      !(pf.io_rail_undervoltage && pf.thermal_shutdown)
      |=> mode_q == SHP_STANDBY && core_init_bit;
   endproperty
   a_init_set: assert property (p_init_set) // RL19
      else $error("fault exit from normal left init clear");

   property p_resume;
      @(posedge sys_clk) disable iff (!rst_n)
      mode_q != SHP_NORMAL ##1 mode_q == SHP_NORMAL
      |-> !core_init_bit && tx_resume;
   endproperty
   a_resume: assert property (p_resume) // RL19
      else $error("normal entry without init clear and resume");

   property p_tsd_sleep;
      @(posedge sys_clk) disable iff (!rst_n)
      mode_q != SHP_SLEEP && pf.io_rail_undervoltage &&
      pf.thermal_shutdown |=> mode_q == SHP_SLEEP ##1 !inhibit_output;
   endproperty
   a_tsd_sleep: assert property (p_tsd_sleep) // RL15
      else $error("rail fault in thermal shutdown missed sleep");

   // Helper count of rail-fault cycles spent outside sleep, saturating.
   always_comb begin
      uv_age_d = 13'h0;
      if (pf.io_rail_undervoltage && mode_q != SHP_SLEEP)
         uv_age_d = (uv_age_q == 13'h1fff) ? uv_age_q : uv_age_q + 13'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         uv_age_q <= 13'h0;
      else
         uv_age_q <= uv_age_d;
   end

   property p_timer_sleep;
      @(posedge sys_clk) disable iff (!rst_n)
      uv_age_q <= 13'(IO_CYC);
   endproperty
   a_timer_sleep: assert property (p_timer_sleep) // RL13
      else $error("rail fault timer did not expire into sleep");

   property p_sleep_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      mode_q == SHP_SLEEP && !pf.wake_event |=> mode_q == SHP_SLEEP;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // RL14
      else $error("left sleep without a wake");

   property p_read_stable;
      @(posedge spi_clk) disable iff (!rf_rst_n)
      cmd_q == `SHP_CMD_RD && hdr_q
      |=> regs_q[$past(idx)] == $past(regs_q[idx]);
   endproperty
   a_read_stable: assert property (p_read_stable) // RL4
      else $error("read changed a register");

   property p_ruv_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(pf.supply_undervoltage) && mode_q != SHP_SLEEP
      |=> regulator_undervoltage ##1 !prot_q.regulator_on;
   endproperty
   a_ruv_flag: assert property (p_ruv_flag) // RL11
      else $error("supply undervoltage flag or regulator off missing");
endmodule : shp_top

// [tb/shp_host.sv]
`timescale 1ns/100ps
// Host processor acting as bus master on the serial port, clock idles low.
module shp_host (
   output logic      spi_clk,
   output logic      host_select_low,
   output logic      serial_in_pin,
   input  wire logic serial_out_pin,
   input  wire logic serial_out_oe_n
);
   logic [31:0] tx_word [0:256];
   logic [31:0] rx_word [0:256];
   logic        first_bit;
   logic        sdo_seen;
   int          oe_bad;

   // A released output is seen inverted, so a missing drive shows up.
   assign sdo_seen = serial_out_oe_n ? ~serial_out_pin : serial_out_pin;

   // Idle levels follow the pull-ups on select and data in.
   initial begin
      spi_clk = 1'b0;
      host_select_low = 1'b1;
      serial_in_pin = 1'b1;
      oe_bad = 0;
   end

   // Deselected clock edges, used only while reset is held.
   task idle_edges(input int n);
      repeat (n) begin
         #7.5 spi_clk = 1'b1;
         #7.5 spi_clk = 1'b0;
      end
   endtask : idle_edges

   // One select-low frame of nbits, sent and sampled MSB first.
   task frame(input int nbits);
      int k;
      host_select_low = 1'b0;
      #5;
      first_bit = sdo_seen;
      for (k = 0; k < nbits; k++) begin
         serial_in_pin = tx_word[k/32][31-(k%32)];
         #2.5 spi_clk = 1'b1;
         rx_word[k/32][31-(k%32)] = sdo_seen;
         if (serial_out_oe_n !== 1'b0) oe_bad++;
         #7.5 spi_clk = 1'b0;
         #5;
      end
      host_select_low = 1'b1;
      serial_in_pin = 1'b1;
      #400;
   endtask : frame
endmodule : shp_host

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "shp_cfg.svh"
module tb_top
   import shp_pkg::*;
;
   logic         sys_clk;
   logic         rst_n;
   logic         spi_clk;
   logic         host_select_low;
   logic         serial_in_pin;
   logic         serial_out_pin;
   logic         serial_out_oe_n;
   shp_pins_type pins;
   logic         flag_clear;
   shp_mode_type mode;
   logic         framing_error_flag;
   logic         regulator_undervoltage;
   logic         io_uv_flag;
   logic         core_init_bit;
   logic         tx_resume;
   logic         inhibit_output;
   shp_prot_type prot;
   int           failures;
   int           n_compared;
   int           n_resume;
   int           i;

   shp_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
      .host_select_low(host_select_low), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
      .pins(pins), .flag_clear(flag_clear), .mode(mode),
      .framing_error_flag(framing_error_flag),
      .regulator_undervoltage(regulator_undervoltage),
      .io_uv_flag(io_uv_flag), .core_init_bit(core_init_bit),
      .tx_resume(tx_resume), .inhibit_output(inhibit_output), .prot(prot));

   shp_host i_host (.spi_clk(spi_clk), .host_select_low(host_select_low),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .serial_out_oe_n(serial_out_oe_n));

   // System clock, 50 ns period.
   always #25 sys_clk = ~sys_clk;

   // Counts cycles with the resume pulse high, one per normal entry.
   always @(posedge sys_clk) if (tx_resume === 1'b1) n_resume++;

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task finish_test;
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick

   task spi(input logic [7:0] cmd, input logic [15:0] adr,
            input logic [7:0] len, input int nbits);
      i_host.tx_word[0] = {cmd, adr, len};
      i_host.frame(nbits);
   endtask : spi

   task pulse_clear;
      flag_clear = 1'b1;
      tick(1);
      flag_clear = 1'b0;
      tick(2);
   endtask : pulse_clear

   // Burst write returns old data, reads return present data.
   task t_regs;
      chk("oe idle", 1, serial_out_oe_n);
      i_host.tx_word[1] = 32'h1234_5678;
      i_host.tx_word[2] = 32'h9abc_def0;
      spi(`SHP_CMD_WR, 16'h0805, 8'h02, 96);
      chk("status word", 32'h0, i_host.rx_word[0]);
      chk("old word a", 32'h0, i_host.rx_word[1]);
      chk("old word b", 32'h0, i_host.rx_word[2]);
      i_host.tx_word[1] = 32'hffff_ffff;
      spi(`SHP_CMD_RD, 16'h0806, 8'h01, 64);
      chk("read a", 32'h1234_5678, i_host.rx_word[1]);
      spi(`SHP_CMD_RD, 16'h0808, 8'h01, 64);
      chk("read b", 32'h9abc_def0, i_host.rx_word[1]);
      i_host.tx_word[1] = 32'h0;
      spi(`SHP_CMD_WR, 16'h0807, 8'h01, 64);
      chk("old after read", 32'h1234_5678, i_host.rx_word[1]);
      spi(`SHP_CMD_RD, 16'h0804, 8'h01, 64);
      chk("rewritten a", 32'h0, i_host.rx_word[1]);
   endtask : t_regs

   // A short last word is dropped and flagged.
   task t_framing;
      i_host.tx_word[1] = 32'h5555_aaaa;
      spi(`SHP_CMD_WR, 16'h0810, 8'h01, 52);
      tick(20);
      chk("framing flag", 1, framing_error_flag);
      spi(`SHP_CMD_RD, 16'h0810, 8'h01, 64);
      chk("dropped word", 32'h0, i_host.rx_word[1]);
      spi(`SHP_CMD_RD, 16'h0810, 8'h01, 64);
      chk("fault at select", 1, i_host.first_bit);
      chk("status byte", 8'hc0, i_host.rx_word[0][31:24]);
      pulse_clear();
      chk("framing cleared", 0, framing_error_flag);
   endtask : t_framing

   // Length byte zero moves 256 words.
   task t_burst;
      for (i = 1; i <= 256; i++) i_host.tx_word[i] = 32'h0100_0000 + i;
      spi(`SHP_CMD_WR, 16'h0800, 8'h00, 32 * 257);
      spi(`SHP_CMD_RD, 16'h0800, 8'h08, 32 * 9);
      for (i = 1; i <= 8; i++)
         chk("burst word", 32'h0100_0000 + i, i_host.rx_word[i]);
      tick(20);
      chk("burst framing", 0, framing_error_flag);
   endtask : t_burst

   // A second power-on reset clears the registers.
   task t_reset;
      rst_n = 1'b0;
      i_host.idle_edges(3);
      tick(20);
      rst_n = 1'b1;
      tick(12);
      spi(`SHP_CMD_RD, 16'h0800, 8'h01, 64);
      chk("cleared by reset", 32'h0, i_host.rx_word[1]);
   endtask : t_reset

   // A fault in normal sets core init; recovery clears it and resumes.
   task t_core_init;
      pins.normal_request = 1'b1;
      tick(8);
      chk("mode normal", SHP_NORMAL, mode);
      chk("resume a", 1, n_resume);
      pins.thermal_shutdown = 1'b1;
      tick(8);
      chk("fault standby", {SHP_STANDBY, 1'b1}, {mode, core_init_bit});
      pins.thermal_shutdown = 1'b0;
      tick(8);
      chk("back normal", {SHP_NORMAL, 1'b0}, {mode, core_init_bit});
      chk("resume b", 2, n_resume);
      pins.normal_request = 1'b0;
      tick(8);
   endtask : t_core_init

   // Core supply undervoltage and its protected outputs.
   task t_supply;
      pins.supply_undervoltage = 1'b1;
      tick(8);
      chk("regulator flag", 1, regulator_undervoltage);
      chk("supply prot", 4'b1101, {prot.bus_float, prot.rx_force_high,
          prot.regulator_on, prot.xcvr_standby});
      pins.xcvr_enable = 1'b0;
      tick(8);
      chk("enable low prot", 2'b01, {prot.wake_rx_on, prot.rx_float});
      pins.supply_undervoltage = 1'b0;
      pins.xcvr_enable = 1'b1;
      tick(8);
      chk("supply back", SHP_STANDBY, mode);
      pulse_clear();
      chk("flag cleared", 0, regulator_undervoltage);
   endtask : t_supply

   // Rail undervoltage times out into sleep; a wake returns to standby.
   task t_io_rail;
      i_host.tx_word[1] = 32'h0f0f_0f0f;
      spi(`SHP_CMD_WR, 16'h0800, 8'h01, 64);
      pins.io_rail_undervoltage = 1'b1;
      tick(8);
      chk("io flag", 1, io_uv_flag);
      chk("io prot", 4'b0111, {prot.host_io_on, prot.bus_recessive,
          prot.rx_float, serial_out_oe_n});
      for (i = 0; i < 4100 && mode !== SHP_SLEEP; i++) tick(1);
      chk("timer length", 1, i >= 3980 && i < 4100);
      if (i == 4100) finish_test();
      tick(2);
      chk("sleep inhibit", 0, inhibit_output);
      pins.io_rail_undervoltage = 1'b0;
      tick(20);
      chk("still asleep", SHP_SLEEP, mode);
      pins.wake_event = 1'b1;
      tick(8);
      pins.wake_event = 1'b0;
      chk("woken", {SHP_STANDBY, 2'b10}, {mode, inhibit_output,
          io_uv_flag});
      tick(12);
      i_host.tx_word[1] = 32'h0;
      spi(`SHP_CMD_WR, 16'h0800, 8'h01, 64);
      chk("cleared by sleep", 32'h0, i_host.rx_word[1]);
   endtask : t_io_rail

   // Rail undervoltage during thermal shutdown sleeps without the timer.
   task t_thermal_io;
      pins.thermal_shutdown = 1'b1;
      tick(8);
      pins.io_rail_undervoltage = 1'b1;
      tick(12);
      chk("direct sleep", SHP_SLEEP, mode);
      pins.thermal_shutdown = 1'b0;
      pins.io_rail_undervoltage = 1'b0;
      pins.wake_event = 1'b1;
      tick(8);
      pins.wake_event = 1'b0;
      chk("woken again", SHP_STANDBY, mode);
   endtask : t_thermal_io

   // Main sequence.
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      pins = '0;
      pins.xcvr_enable = 1'b1;
      flag_clear = 1'b0;
      failures = 0;
      n_compared = 0;
      n_resume = 0;
      i_host.idle_edges(3);
      tick(20);
      rst_n = 1'b1;
      tick(12);
      t_regs();
      t_framing();
      t_burst();
      t_reset();
      t_core_init();
      t_supply();
      t_io_rail();
      t_thermal_io();
      chk("oe in frames", 0, i_host.oe_bad);
      finish_test();
   end
endmodule : tb_top
